// file: rtl/ioit_cpu_end.sv
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ioit_cpu_end
  import ioit_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  ioit_link_if.cpu               link,
  input  wire logic              instr_valid,
  input  wire logic [WORD_W-1:0] instr,
  input  wire logic [ADDR_W-1:0] index_value,
  output logic                   mem_rd,
  output logic [ADDR_W-1:0]      mem_addr,
  input  wire logic [WORD_W-1:0] mem_rdata,
  output logic                   instr_done,
  output logic                   skip_next,
  output logic                   illegal_op
);
  typedef struct packed {
    ioit_state_t       st;
    logic [CHAN_W-1:0] ch;
    logic [IND_W-1:0]  mask;
    logic [ADDR_W-1:0] addr;
    logic              ind;
    logic              is_test;
    logic [WORD_W-1:0] data;
    logic              rd;
    logic              done;
    logic              skip;
    logic              ill;
    logic [NCHAN-1:0]  ilk;
  } ioit_cpu_t;

  ioit_cpu_t s_reg, s_next;
  logic [5:0]             op;
  logic                   f_indir;
  logic [3:0]             f_xreg;
  logic [CHAN_W-1:0]      f_chan;
  logic [ADDR_W-1:0]      f_m;
  logic [IND_W-1:0]       chan_ind;
  logic [NCHAN*IND_W-1:0] ind_bus;

  // effective address; index register 0 adds nothing, carries are lost
  function automatic logic [ADDR_W-1:0] eff_addr(
    input logic [ADDR_W-1:0] m,
    input logic [3:0]        xreg,
    input logic [ADDR_W-1:0] xval
  );
    logic [ADDR_W-1:0] x;
    x = (xreg != 4'h0) ? xval : '0;
    return m + x;
  endfunction

  // indicators of one channel as the test sees them
  function automatic logic [IND_W-1:0] sel_ind(
    input logic [NCHAN*IND_W-1:0] bus,
    input logic [CHAN_W-1:0]      ch,
    input logic [NCHAN-1:0]       ilk
  );
    logic [IND_W-1:0] v;
    v = bus[ch*IND_W +: IND_W];
    v[IND_INTERLOCK] = ilk[ch];
    v = v & IND_DEFINED_MASK;
    if (ioit_chan_class(ch) == IOIT_CLS_NONE)
      v = '0;
    return v;
  endfunction

  assign op       = instr[IW_OP_HI:IW_OP_LO];
  assign f_indir  = instr[IW_IND_BIT];
  assign f_xreg   = instr[IW_X_HI:IW_X_LO];
  assign f_chan   = instr[IW_CH_HI:IW_CH_LO];
  assign f_m      = instr[IW_M_HI:IW_M_LO];
  assign ind_bus  = link.ind;
  assign chan_ind = sel_ind(ind_bus, s_reg.ch, s_reg.ilk);

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.rd = 1'b0;
    s_next.ill = 1'b0;
    // synchronizer clears; a set in the same cycle wins below
    s_next.ilk = s_reg.ilk & ~link.interlock_clr;
    case (s_reg.st)
      IOIT_ST_IDLE: begin
        if (instr_valid) begin
          s_next.ch = f_chan;
          s_next.mask = f_m;
          s_next.ind = f_indir;
          s_next.addr = eff_addr(f_m, f_xreg, index_value);
          s_next.is_test = (op == OP_TEST);
          if (op == OP_INITIATE) begin
            s_next.rd = 1'b1;
            s_next.st = f_indir ? IOIT_ST_ADDR : IOIT_ST_READ;
          end else if (op == OP_TEST) begin
            s_next.st = f_indir ? IOIT_ST_ADDR : IOIT_ST_TEST;
            s_next.rd = f_indir;
          end else begin
            s_next.ill = 1'b1;
            s_next.done = 1'b1;
          end
        end
      end
      IOIT_ST_ADDR: begin
        // indirect: the fetched word supplies the effective address
        s_next.addr = mem_rdata[IW_M_HI:IW_M_LO];
        s_next.rd = !s_reg.is_test;
        s_next.st = s_reg.is_test ? IOIT_ST_TEST : IOIT_ST_READ;
      end
      IOIT_ST_READ: begin
        // memory answers within the read cycle; the word is taken at its end
        s_next.data = mem_rdata;
        s_next.st = IOIT_ST_WRITE;
      end
      IOIT_ST_WRITE: begin
        s_next.ilk[s_reg.ch] = 1'b1;
        s_next.done = 1'b1;
        s_next.st = IOIT_ST_IDLE;
      end
      IOIT_ST_TEST: begin
        s_next.skip = ~|(chan_ind & s_reg.mask);
        s_next.done = 1'b1;
        s_next.st = IOIT_ST_IDLE;
      end
      default: s_next.st = IOIT_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign mem_rd = s_reg.rd;
  assign mem_addr = s_reg.addr;
  assign instr_done = s_reg.done;
  assign skip_next = s_reg.skip;
  assign illegal_op = s_reg.ill;
  assign link.interlock = s_reg.ilk;
  assign link.st_we = (s_reg.st == IOIT_ST_WRITE);
  assign link.st_addr = s_reg.ch;
  assign link.st_wdata = s_reg.data;
  assign link.sy_rdata = '0;
endmodule
`default_nettype wire

// file: rtl/ioit_pkg.sv
package ioit_pkg;
  localparam int unsigned WORD_W     = 25;
  localparam int unsigned ADDR_W     = 10;
  localparam int unsigned CHAN_W     = 4;
  localparam int unsigned IND_W      = 10;
  localparam int unsigned NCHAN      = 16;
  // instruction word fields (bit 1 of the word is index 0)
  localparam int unsigned IW_IND_BIT = 24;
  localparam int unsigned IW_X_HI    = 23;
  localparam int unsigned IW_X_LO    = 20;
  localparam int unsigned IW_OP_HI   = 19;
  localparam int unsigned IW_OP_LO   = 14;
  localparam int unsigned IW_CH_HI   = 13;
  localparam int unsigned IW_CH_LO   = 10;
  localparam int unsigned IW_M_HI    = 9;
  localparam int unsigned IW_M_LO    = 0;
  // operation codes are printed in octal
  localparam logic [5:0] OP_INITIATE = 6'o70;
  localparam logic [5:0] OP_TEST     = 6'o64;
  localparam int unsigned CYC_INITIATE = 3;
  localparam int unsigned CYC_TEST     = 2;
  // channel designations
  localparam logic [3:0] CH_TAPE_WR   = 4'h3;
  localparam logic [3:0] CH_TAPE_RD   = 4'h4;
  localparam logic [3:0] CH_GP_FIRST  = 4'h5;
  localparam logic [3:0] CH_GP_LAST   = 4'hc;
  localparam logic [3:0] CH_COMPAT    = 4'hd;
  localparam logic [3:0] CH_ADD_WR    = 4'he;
  localparam logic [3:0] CH_ADD_RD    = 4'hf;
  // indicator positions (bit n of the mask is index n-1)
  localparam int unsigned IND_INTERLOCK = 0;
  localparam int unsigned IND_DONE      = 1;
  localparam int unsigned IND_DATA_ERR  = 4;
  localparam int unsigned IND_FAULT     = 6;
  // indicators defined for a channel: bits 1 to 7, the rest test as clear
  localparam logic [IND_W-1:0] IND_DEFINED_MASK = 10'h07f;
  // function specification: function code in bits 20-17
  localparam int unsigned FS_FN_HI = 19;
  localparam int unsigned FS_FN_LO = 16;
  localparam int unsigned FS_CONT_BIT = 19;
  localparam logic [3:0] FN_GATHER_WRITE   = 4'h1;
  localparam logic [3:0] FN_OVERLAY_GW     = 4'h5;
  localparam logic [3:0] FN_FWD_SCATTER    = 4'h0;
  localparam logic [3:0] FN_BWD_SCATTER    = 4'h2;
  localparam logic [3:0] FN_FWD_BLOCK      = 4'h4;
  localparam logic [3:0] FN_BWD_BLOCK      = 4'h6;
  localparam logic [3:0] FN_REWIND_ILK     = 4'h7;
  localparam logic [3:0] FN_REWIND         = 4'h3;
  localparam logic [3:0] FN_LOAD_POINT     = 4'hf;
  localparam logic [3:0] FN_C_REWIND_ILK   = 4'hb;
  localparam logic [3:0] FN_PUNCH_STK1     = 4'h4;
  localparam logic [1:0] FN_ADVANCE_PRINT  = 2'h2;
  localparam logic [1:0] FN_ADVANCE        = 2'h0;
  localparam logic [9:0] LEN_COMPAT   = 10'd180;
  localparam logic [9:0] LEN_CARD_TR  = 10'd20;
  localparam logic [9:0] LEN_CARD_RAW = 10'd40;
  localparam logic [9:0] LEN_CARD_90  = 10'd24;
  localparam logic [9:0] LEN_PRINT    = 10'd32;

  typedef enum logic [1:0] {
    IOIT_CLS_TAPE, IOIT_CLS_CARD, IOIT_CLS_PRINT, IOIT_CLS_NONE
  } ioit_cls_t;

  typedef enum logic [2:0] {
    IOIT_ST_IDLE, IOIT_ST_ADDR, IOIT_ST_READ, IOIT_ST_WRITE, IOIT_ST_TEST
  } ioit_state_t;

  typedef enum logic [1:0] {
    IOIT_SY_IDLE, IOIT_SY_FETCH, IOIT_SY_RUN
  } ioit_sync_state_t;

  // channel class of a designation
  function automatic ioit_cls_t ioit_chan_class(input logic [3:0] ch);
    ioit_cls_t c;
    c = IOIT_CLS_NONE;
    if (ch == CH_TAPE_WR || ch == CH_TAPE_RD || ch == CH_COMPAT ||
        ch == CH_ADD_WR || ch == CH_ADD_RD)
      c = IOIT_CLS_TAPE;
    else if (ch >= CH_GP_FIRST && ch <= CH_GP_LAST)
      c = IOIT_CLS_CARD;
    return c;
  endfunction
endpackage

// file: rtl/ioit_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ioit_link_if;
  import ioit_pkg::*;
  logic [CHAN_W-1:0] st_addr;
  logic [WORD_W-1:0] st_wdata;
  logic              st_we;
  logic [CHAN_W-1:0] sy_addr;
  logic [WORD_W-1:0] sy_rdata;
  logic [NCHAN-1:0]  interlock;
  logic [NCHAN-1:0]  interlock_clr;
  logic [NCHAN*IND_W-1:0] ind;

  modport cpu (
    output st_addr, st_wdata, st_we, interlock,
    input  sy_addr, interlock_clr, ind,
    output sy_rdata
  );
  modport sync (
    input  st_addr, st_wdata, st_we, interlock, sy_rdata,
    output sy_addr, interlock_clr, ind
  );
endinterface
`default_nettype wire

// file: rtl/ioit_sync_chan.sv
`timescale 1ns/1ps
`default_nettype none
module ioit_sync_chan
  import ioit_pkg::*;
#(
  parameter logic [3:0] CHAN = 4'h3
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              ilk,
  input  wire logic [WORD_W-1:0] spec,
  input  wire logic              dev_ready,
  input  wire logic              dev_started,
  input  wire logic              dev_done,
  input  wire logic [IND_W-1:0]  dev_flags,
  output logic                   clr,
  output logic                   go,
  output logic [WORD_W-1:0]      spec_out,
  output logic [9:0]             length,
  output logic [IND_W-1:0]       flags
);
  typedef struct packed {
    ioit_sync_state_t st;
    logic [WORD_W-1:0] spec;
    logic [9:0]        len;
    logic              go;
    logic              done;
    logic              pend;
  } ioit_sc_t;

  ioit_sc_t s_reg, s_next;
  ioit_cls_t cls;
  logic [3:0] fn;

  assign cls = ioit_chan_class(CHAN);
  assign fn  = s_reg.spec[FS_FN_HI:FS_FN_LO];

  always_comb begin
    s_next = s_reg;
    s_next.go = 1'b0;
    clr = 1'b0;
    case (s_reg.st)
      IOIT_SY_IDLE: begin
        if (ilk && dev_ready) begin
          s_next.spec = spec;
          s_next.st = IOIT_SY_FETCH;
        end
      end
      IOIT_SY_FETCH: begin
        s_next.done = 1'b0;
        s_next.len = 10'd0;
        if (cls == IOIT_CLS_CARD) begin
          clr = 1'b1;
          s_next.len = fn[1] ? LEN_CARD_TR : LEN_CARD_RAW;
        end else if (CHAN == CH_COMPAT) begin
          if (fn[1:0] != 2'b11)
            s_next.len = LEN_COMPAT;
        end else if (cls == IOIT_CLS_PRINT) begin
          if (fn[1:0] == FN_ADVANCE_PRINT)
            s_next.len = LEN_PRINT;
        end
        if (cls == IOIT_CLS_TAPE &&
            (fn == FN_REWIND || fn == FN_REWIND_ILK || fn == FN_LOAD_POINT))
          s_next.len = 10'd0;
        s_next.pend = (cls != IOIT_CLS_CARD);
        s_next.go = 1'b1;
        s_next.st = IOIT_SY_RUN;
      end
      IOIT_SY_RUN: begin
        // one clear per fetched specification; a later set is a new order
        if (dev_started && s_reg.pend) begin
          clr = 1'b1;
          s_next.pend = 1'b0;
        end
        if (dev_done) begin
          s_next.done = 1'b1;
          s_next.st = IOIT_SY_IDLE;
        end
      end
      default: s_next.st = IOIT_SY_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign go = s_reg.go;
  assign spec_out = s_reg.spec;
  assign length = s_reg.len;
  // done sits in the successful-completion position
  always_comb begin
    flags = dev_flags;
    flags[IND_INTERLOCK] = 1'b0;
    flags[IND_DONE] = s_reg.done | dev_flags[IND_DONE];
  end
endmodule
`default_nettype wire

// file: rtl/ioit_sync_end.sv
`timescale 1ns/1ps
`default_nettype none
module ioit_sync_end
  import ioit_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   reset,
  ioit_link_if.sync                   link,
  input  wire logic [NCHAN-1:0]       dev_ready,
  input  wire logic [NCHAN-1:0]       dev_started,
  input  wire logic [NCHAN-1:0]       dev_done,
  input  wire logic [NCHAN*IND_W-1:0] dev_flags,
  output logic [NCHAN-1:0]            dev_go,
  output logic [NCHAN*WORD_W-1:0]     dev_spec,
  output logic [NCHAN*10-1:0]         dev_len
);
  // one synchronizer per active channel; each reads its own standby word
  logic [NCHAN*WORD_W-1:0] words;
  logic [NCHAN-1:0] clr;
  genvar g;
  for (g = 0; g < NCHAN; g++) begin : g_ch
    if (g >= 3) begin : g_on
      always_ff @(posedge mclk) begin
        if (reset)
          words[g*WORD_W +: WORD_W] <= '0;
        else if (link.st_we && link.st_addr == CHAN_W'(g))
          words[g*WORD_W +: WORD_W] <= link.st_wdata;
      end
      ioit_sync_chan #(.CHAN(CHAN_W'(g))) u_ch (
        .mclk        (mclk),
        .reset       (reset),
        .ilk         (link.interlock[g]),
        .spec        (words[g*WORD_W +: WORD_W]),
        .dev_ready   (dev_ready[g]),
        .dev_started (dev_started[g]),
        .dev_done    (dev_done[g]),
        .dev_flags   (dev_flags[g*IND_W +: IND_W]),
        .clr         (clr[g]),
        .go          (dev_go[g]),
        .spec_out    (dev_spec[g*WORD_W +: WORD_W]),
        .length      (dev_len[g*10 +: 10]),
        .flags       (link.ind[g*IND_W +: IND_W])
      );
    end else begin : g_off
      assign words[g*WORD_W +: WORD_W] = '0;
      assign clr[g] = 1'b0;
      assign dev_go[g] = 1'b0;
      assign dev_spec[g*WORD_W +: WORD_W] = '0;
      assign dev_len[g*10 +: 10] = '0;
      assign link.ind[g*IND_W +: IND_W] = '0;
    end
  end
  assign link.interlock_clr = clr;
  assign link.sy_addr = '0;
endmodule
`default_nettype wire

// file: verification/ioit_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ioit_assertions
  import ioit_pkg::*;
(
  input wire logic                   mclk,
  input wire logic                   reset,
  input wire logic [CHAN_W-1:0]      st_addr,
  input wire logic [WORD_W-1:0]      st_wdata,
  input wire logic                   st_we,
  input wire logic [NCHAN-1:0]       interlock,
  input wire logic [NCHAN-1:0]       interlock_clr,
  input wire logic [NCHAN*IND_W-1:0] ind
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  we_sets_ilk_a: assert property (
    st_we |=> interlock[$past(st_addr)]) else $error("interlock not set");
  ilk_rise_cause_a: assert property (
    (interlock & ~$past(interlock)) != 16'h0 |-> st_we || $past(st_we))
    else $error("interlock set without standby write");
  we_spacing_a: assert property (
    st_we |=> !st_we [*2]) else $error("standby writes too close");
  clr_only_set_a: assert property (
    (interlock_clr & ~interlock) == 16'h0) else $error("clear of idle channel");
  clr_drops_ilk_a: assert property (
    |interlock_clr && !st_we && !$past(st_we)
    |=> (interlock & $past(interlock_clr)) == 16'h0)
    else $error("interlock kept after clear");
  ilk_fall_cause_a: assert property (
    ($past(interlock) & ~interlock & ~$past(interlock_clr)) == 16'h0)
    else $error("interlock dropped without clear");
  clr_pulse_a: assert property (
    (interlock_clr & $past(interlock_clr)) == 16'h0)
    else $error("clear pulse too long");
  clr_low_chan_a: assert property (
    interlock_clr[2:0] == 3'h0) else $error("clear on unused channel");
  ind_low_chan_a: assert property (
    ind[3*IND_W-1:0] == '0) else $error("indicator on unused channel");
endmodule
`default_nettype wire

// file: verification/ioit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ioit_tb_top;
  import ioit_pkg::*;
  typedef struct {
    int                kind;
    int                lat;
    logic              skip;
    logic [3:0]        ch;
    logic [WORD_W-1:0] spec;
  } ioit_note_t;
  logic                   mclk = 1'b0;
  logic                   reset = 1'b1;
  logic                   instr_valid = 1'b0;
  logic [WORD_W-1:0]      instr = 25'h0;
  logic [ADDR_W-1:0]      index_value = 10'h0;
  logic [WORD_W-1:0]      mem_rdata;
  logic [3:0]             rch;
  logic [NCHAN-1:0]       dev_ready = 16'h0;
  logic [NCHAN-1:0]       dev_started = 16'h0;
  logic [NCHAN-1:0]       dev_done = 16'h0;
  logic [NCHAN*IND_W-1:0] dev_flags = 160'h0;
  logic                   mem_rd, instr_done, skip_next, illegal_op;
  logic [ADDR_W-1:0]      mem_addr;
  logic [NCHAN-1:0]       dev_go;
  logic [NCHAN*WORD_W-1:0] dev_spec;
  logic [NCHAN*10-1:0]    dev_len;
  logic [WORD_W-1:0]      mem [0:1023];
  logic [WORD_W-1:0]      exp_spec [NCHAN];
  ioit_note_t             notes [$];
  int                     failures = 0;
  int                     num_checks = 0;
  int                     cyc = 0;
  int                     t0 = 0;
  logic [31:0]            seed = 32'h4fb1a125;

  ioit_link_if lk ();
  ioit_cpu_end i_ioit_cpu_end (.mclk(mclk), .reset(reset), .link(lk),
    .instr_valid(instr_valid), .instr(instr), .index_value(index_value),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .instr_done(instr_done), .skip_next(skip_next), .illegal_op(illegal_op));
  ioit_sync_end i_ioit_sync_end (.mclk(mclk), .reset(reset), .link(lk),
    .dev_ready(dev_ready), .dev_started(dev_started), .dev_done(dev_done),
    .dev_flags(dev_flags), .dev_go(dev_go), .dev_spec(dev_spec),
    .dev_len(dev_len));
  ioit_assertions i_chk (.mclk(mclk), .reset(reset), .st_addr(lk.st_addr),
    .st_wdata(lk.st_wdata), .st_we(lk.st_we), .interlock(lk.interlock),
    .interlock_clr(lk.interlock_clr), .ind(lk.ind));

  always #25 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  // memory answers within the read cycle; outside it the bits are inverted
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [9:0] exp_len(input logic [3:0] ch,
                                         input logic [3:0] fn);
    if (ch >= CH_GP_FIRST && ch <= CH_GP_LAST)
      return fn[1] ? LEN_CARD_TR : LEN_CARD_RAW;
    if (ch == CH_COMPAT && fn[1:0] != 2'b11)
      return LEN_COMPAT;
    return 10'h0;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic issue(input logic [WORD_W-1:0] w, input logic [9:0] idx,
                       input ioit_note_t n);
    int i;
    notes.push_back(n);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr <= w;
    index_value <= idx;
    @(posedge mclk);
    instr_valid <= 1'b0;
    i = 0;
    do begin
      @(negedge mclk);
      i++;
    end while (instr_done !== 1'b1 && i < 20);
    if (i >= 20) begin
      failures++;
      end_of_test();
    end
  endtask

  task automatic initiate(input logic [3:0] ch, input logic indir);
    ioit_note_t n;
    logic [9:0] m, idx, ea, p;
    n = '{0, indir ? 4 : 3, 1'b0, ch, WORD_W'(rnd())};
    m = 10'(rnd());
    idx = indir ? 10'h0 : 10'(rnd());
    ea = m + idx;
    p = ea ^ 10'h200;
    if (indir) mem[ea] = {15'h0, p};
    mem[indir ? p : ea] = n.spec;
    issue({indir, indir ? 4'h0 : 4'h1, OP_INITIATE, ch, m}, idx, n);
  endtask

  task automatic test(input logic [3:0] ch, input logic [9:0] mask,
                      input logic skip);
    issue({5'h0, OP_TEST, ch, mask}, 10'h0, '{1, 2, skip, ch, 25'h0});
  endtask

  always @(negedge mclk) begin
    ioit_note_t n;
    if (instr_valid) t0 = cyc;
    if (instr_done === 1'b1) begin
      n = notes.pop_front();
      if (n.lat > 0) chk("latency", n.lat, cyc - t0);
      chk("illegal", n.kind == 2, illegal_op);
      if (n.kind == 1) chk("skip", n.skip, skip_next);
      if (n.kind == 0) begin
        chk("standby", {1'b1, n.ch, n.spec},
          {lk.interlock[n.ch], lk.st_addr, lk.st_wdata});
        exp_spec[n.ch] = n.spec;
      end
    end
    for (int k = 0; k < NCHAN; k++)
      if (dev_go[k] === 1'b1) begin
        chk("spec", exp_spec[k], dev_spec[k*WORD_W +: WORD_W]);
        chk("length", exp_len(4'(k), exp_spec[k][FS_FN_HI:FS_FN_LO]),
          dev_len[k*10 +: 10]);
      end
  end

  initial begin
    for (int a = 0; a < 1024; a++) mem[a] = WORD_W'(rnd());
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    for (int c = 3; c < 16; c++) initiate(4'(c), c[0]);
    initiate(4'h5, 1'b0);
    for (int c = 3; c < 16; c++) test(4'(c), 10'h001, 1'b0);
    dev_ready <= 16'hffff;
    repeat (4) @(posedge mclk);
    test(4'h5, 10'h001, 1'b1);
    test(4'h3, 10'h001, 1'b0);
    dev_started <= 16'hffff;
    repeat (4) @(posedge mclk);
    test(4'h3, 10'h001, 1'b1);
    dev_flags[4*IND_W +: IND_W] <= 10'h202;
    repeat (2) @(posedge mclk);
    test(4'h4, 10'h002, 1'b0);
    test(4'h4, 10'h200, 1'b1);
    test(4'h4, 10'h000, 1'b1);
    test(4'h4, 10'h3fc, 1'b1);
    test(4'h4, 10'h002, 1'b0);
    dev_done <= 16'hffff;
    issue({5'h0, 6'o00, 4'h3, 10'h0}, 10'h0, '{2, -1, 1'b0, 4'h3, 25'h0});
    for (int r = 0; r < 8; r++) begin
      rch = 4'h3 + 4'(rnd() % 13);
      repeat (4) @(posedge mclk);
      test(rch, 10'h001, 1'b1);
      initiate(rch, rnd() % 2 == 0);
    end
    repeat (6) @(posedge mclk);
    end_of_test();
  end
endmodule
`default_nettype wire
